// file: mcp_control_pins.v
// Purpose: reset, reload button, boot-done, link and pulse outputs of a serial module
// Assumes: one 20 MHz clock; reload button and link status come from pins
// Notes: boot and restore durations stand in for firmware activity
`timescale 1ns/10ps
`include "mcp_map.vh"
// Notes on behaviour
// RL1: host holds module reset low at least 10 ms, then releases it.
// RL2: reload low during boot selects the upgrade mode.
// RL3: reload press under 2 s after power-up enters provisioning mode.
// RL4: reload press over 4 s then release restores factory defaults.
// RL5: after the factory restore completes, boot restarts from the beginning.
// RL6: a release between 2 s and 4 s changes nothing.
// RL7: boot-done goes low after normal boot, stays high otherwise.
// RL8: host uses the serial port only after boot-done is low.
// RL9: in normal mode link output is low while associated, else high.
// RL10: link output shows upgrade progress or provisioning completion in those modes.
// RL11: channels 0-4 and 5 give 1-100% duty over their period ranges.
module mcp_control_pins #(
    parameter [`MCP_CNT_W-1:0] SHORT_CYCLES = `MCP_SHORT_MS * (`MCP_CLK_HZ / `MCP_MS_PER_SEC),
    parameter [`MCP_CNT_W-1:0] LONG_CYCLES = `MCP_LONG_MS * (`MCP_CLK_HZ / `MCP_MS_PER_SEC),
    parameter [`MCP_CNT_W-1:0] BOOT_CYCLES = `MCP_BOOT_MS * (`MCP_CLK_HZ / `MCP_MS_PER_SEC),
    parameter [`MCP_CNT_W-1:0] RESTORE_CYCLES = `MCP_RESTORE_MS * (`MCP_CLK_HZ / `MCP_MS_PER_SEC),
    parameter CHANNELS = 6
) (
    input wire sys_clk,
    input wire rst_n,
    input wire reload_button_n,
    input wire apAssociated,
    input wire upgradeActivity,
    input wire provDone,
    input wire [CHANNELS-1:0] pulseEnable,
    input wire [CHANNELS*`MCP_PW_W-1:0] pulsePeriod,
    input wire [CHANNELS*`MCP_PW_W-1:0] pulseHigh,
    output reg boot_done_n,
    output reg wifi_link_n,
    output reg provisionMode,
    output reg upgradeMode,
    output reg factoryRestore,
    output wire [CHANNELS-1:0] pulse_out
);
    reg [1:0] reloadSync_q;
    reg [1:0] assocSync_q;
    reg [1:0] upgSync_q;
    reg [1:0] provSync_q;
    reg [`MCP_ST_W-1:0] state_q;
    reg [`MCP_ST_W-1:0] state_d;
    reg [`MCP_CNT_W-1:0] timer_q;
    reg [`MCP_CNT_W-1:0] press_q;
    reg reloadLow_q;
    wire reloadLow;
    wire released;
    wire timerDone;
    wire [`MCP_CNT_W-1:0] timerLimit;
    reg [`MCP_CNT_W-1:0] timer_d;
    reg [`MCP_CNT_W-1:0] press_d;
    reg bootDoneN_d;
    reg linkN_d;

    // second stages only are read by logic
    // reload idles high, so its stages reset high: no false release after reset
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reloadSync_q <= 2'h3;
            assocSync_q <= 2'h0;
            upgSync_q <= 2'h0;
            provSync_q <= 2'h0;
        end
        else
        begin
            reloadSync_q <= {reloadSync_q[0], reload_button_n};
            assocSync_q <= {assocSync_q[0], apAssociated};
            upgSync_q <= {upgSync_q[0], upgradeActivity};
            provSync_q <= {provSync_q[0], provDone};
        end
    end

    assign reloadLow = ~reloadSync_q[1];
    assign released = reloadLow_q & ~reloadLow;
    assign timerLimit = (state_q == `MCP_ST_RESTORE) ? RESTORE_CYCLES : BOOT_CYCLES;
    assign timerDone = (timer_q >= timerLimit - 32'h00000001);

    // reset itself is the asynchronous rst_n, held by the host [RL1]
    always @*
    begin
        state_d = state_q;
        case (state_q)
            `MCP_ST_BOOT:
            begin
                if (reloadLow)
                begin
                    state_d = `MCP_ST_UPGRADE; // [RL2]
                end
                else if (timerDone)
                begin
                    state_d = `MCP_ST_NORMAL;
                end
            end
            `MCP_ST_NORMAL, `MCP_ST_PROV:
            begin
                if (released && press_q > LONG_CYCLES)
                begin
                    state_d = `MCP_ST_RESTORE; // [RL4]
                end
                else if (released && press_q < SHORT_CYCLES)
                begin
                    state_d = `MCP_ST_PROV; // [RL3]
                end
                // releases between the limits fall through unchanged [RL6]
            end
            `MCP_ST_UPGRADE:
            begin
                // sticky: only rst_n leaves upgrade, the button is ignored here
                state_d = `MCP_ST_UPGRADE;
            end
            `MCP_ST_RESTORE:
            begin
                if (timerDone)
                begin
                    state_d = `MCP_ST_BOOT; // [RL5]
                end
            end
            default:
            begin
                state_d = `MCP_ST_BOOT;
            end
        endcase
    end

    // one timer serves boot and restore; it restarts on every state change
    always @*
    begin
        timer_d = timer_q + 32'h00000001;
        if (state_d != state_q)
        begin
            timer_d = {`MCP_CNT_W{1'b0}};
        end
    end

    // saturate so a very long press still counts as long
    always @*
    begin
        press_d = press_q;
        if (!reloadLow)
        begin
            press_d = {`MCP_CNT_W{1'b0}};
        end
        else if (press_q != {`MCP_CNT_W{1'b1}})
        begin
            press_d = press_q + 32'h00000001;
        end
    end

    // decoded from the next state so pins change with state_q, not a cycle later
    always @*
    begin
        bootDoneN_d = 1'b1;
        linkN_d = 1'b1;
        case (state_d)
            `MCP_ST_NORMAL:
            begin
                bootDoneN_d = 1'b0; // [RL7]
                linkN_d = ~assocSync_q[1]; // [RL9]
            end
            `MCP_ST_UPGRADE:
            begin
                linkN_d = ~upgSync_q[1]; // [RL10]
            end
            `MCP_ST_PROV:
            begin
                bootDoneN_d = 1'b0; // [RL7]
                linkN_d = ~provSync_q[1]; // [RL10]
            end
            default:
            begin
                bootDoneN_d = 1'b1;
                linkN_d = 1'b1;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= `MCP_ST_BOOT;
            timer_q <= {`MCP_CNT_W{1'b0}};
            press_q <= {`MCP_CNT_W{1'b0}};
            reloadLow_q <= 1'b0;
            boot_done_n <= 1'b1;
            wifi_link_n <= 1'b1;
            provisionMode <= 1'b0;
            upgradeMode <= 1'b0;
            factoryRestore <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            reloadLow_q <= reloadLow;
            timer_q <= timer_d;
            press_q <= press_d;
            boot_done_n <= bootDoneN_d;
            wifi_link_n <= linkN_d;
            upgradeMode <= (state_d == `MCP_ST_UPGRADE); // [RL2]
            provisionMode <= (state_d == `MCP_ST_PROV); // [RL3]
            factoryRestore <= (state_d == `MCP_ST_RESTORE); // [RL4]
        end
    end

    // period and high time in cycles; 5 us is 100 cycles at 20 MHz [RL11]
    // a disabled channel restarts its period and holds its output low
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1)
        begin : gChan
            mcp_pulse_chan #(
                .W(`MCP_PW_W)
            ) uChan (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .enable(pulseEnable[i]),
                .periodCycles(pulsePeriod[i*`MCP_PW_W +: `MCP_PW_W]),
                .highCycles(pulseHigh[i*`MCP_PW_W +: `MCP_PW_W]),
                .pulseOut_q(pulse_out[i])
            );
        end
    endgenerate
endmodule // mcp_control_pins

// file: mcp_map.vh
// Purpose: constants for the module control pin logic
// Assumes: sys_clk at 20 MHz
// Notes: times in their own unit, cycle counts derived
`ifndef MCP_MAP_VH
`define MCP_MAP_VH
`define MCP_CLK_HZ 20000000
`define MCP_MS_PER_SEC 1000
`define MCP_SHORT_MS 2000
`define MCP_LONG_MS 4000
`define MCP_BOOT_MS 100
`define MCP_RESTORE_MS 50
`define MCP_CNT_W 32
`define MCP_ST_W 3
`define MCP_ST_BOOT 3'h0
`define MCP_ST_NORMAL 3'h1
`define MCP_ST_UPGRADE 3'h2
`define MCP_ST_PROV 3'h3
`define MCP_ST_RESTORE 3'h4
`define MCP_PW_W 32
`endif

// file: mcp_pulse_chan.v
// Purpose: one pulse-width channel
// Assumes: period and high time given in sys_clk cycles
// Notes: high time at or above period gives 100% duty
`timescale 1ns/10ps
module mcp_pulse_chan #(
    parameter W = 32
) (
    input wire sys_clk,
    input wire rst_n,
    input wire enable,
    input wire [W-1:0] periodCycles,
    input wire [W-1:0] highCycles,
    output reg pulseOut_q
);
    reg [W-1:0] count_q;
    wire lastCycle;
    assign lastCycle = (count_q >= periodCycles - {{(W-1){1'b0}}, 1'b1});
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= {W{1'b0}};
            pulseOut_q <= 1'b0;
        end
        else if (!enable)
        begin
            count_q <= {W{1'b0}};
            pulseOut_q <= 1'b0;
        end
        else
        begin
            count_q <= lastCycle ? {W{1'b0}} : count_q + {{(W-1){1'b0}}, 1'b1};
            pulseOut_q <= (count_q < highCycles);
        end
    end
endmodule // mcp_pulse_chan

// file: mcp_host_model.sv
// Purpose: host and reload button model
// Assumes: one press at a time
// Notes: reset hold shortened
`timescale 1ns/10ps
module mcp_host_model #(parameter HOLD = 20)
(
    input wire sys_clk,
    input wire doReset,
    input wire press,
    input wire [7:0] pressLen,
    input wire boot_done_n,
    output reg rst_n = 1'b0,
    output reg reload_button_n = 1'b1,
    output wire serialOk
);
integer rc = 0;
integer pc = 0;
assign serialOk = !boot_done_n;
always @(posedge sys_clk)
begin
    rc <= doReset ? HOLD : (rc > 0 ? rc - 1 : 0);
    rst_n <= !(doReset || rc > 1);
    pc <= press ? pressLen : (pc > 0 ? pc - 1 : 0);
    reload_button_n <= !(press || pc > 1);
end
endmodule // mcp_host_model

// file: mcp_checker_assertions.sv
// Purpose: output timing checks
// Assumes: restore 5 and boot 10 cycles
// Notes: bound below
`timescale 1ns/10ps
module mcp_checker (
    input wire sys_clk,
    input wire rst_n,
    input wire apAssociated,
    input wire upgradeActivity,
    input wire provDone,
    input wire boot_done_n,
    input wire wifi_link_n,
    input wire provisionMode,
    input wire upgradeMode,
    input wire factoryRestore
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
a_boot_idle: assert property ($rose(rst_n) |-> boot_done_n && wifi_link_n) else $error("b");
a_modes_excl: assert property ($onehot0({provisionMode, upgradeMode, factoryRestore}))
    else $error("m");
a_busy_high: assert property (upgradeMode || factoryRestore |-> boot_done_n) else $error("u");
a_prov_ready: assert property (provisionMode |-> !boot_done_n) else $error("p");
a_boot_len: assert property ($fell(boot_done_n) |-> $past(boot_done_n, 9)) else $error("l");
a_restore_reboot: assert property ($rose(factoryRestore) |-> factoryRestore[*5] ##[1:2]
    (!factoryRestore && boot_done_n)) else $error("r");
a_upgrade_stay: assert property (upgradeMode |=> upgradeMode) else $error("s");
a_link_idle: assert property (boot_done_n && !upgradeMode && $past(boot_done_n)
    |-> wifi_link_n) else $error("i");
a_link_assoc: assert property ((!boot_done_n && !provisionMode && apAssociated)[*4]
    |-> !wifi_link_n) else $error("a");
a_prov_link: assert property ((provisionMode && provDone)[*4] |-> !wifi_link_n)
    else $error("q");
a_upg_link: assert property ((upgradeMode && upgradeActivity)[*4] |-> !wifi_link_n)
    else $error("g");
endmodule // mcp_checker
bind mcp_control_pins mcp_checker chk (.sys_clk, .rst_n, .apAssociated, .upgradeActivity,
    .provDone, .boot_done_n, .wifi_link_n, .provisionMode, .upgradeMode, .factoryRestore);

// file: mcp_control_pins_test.sv
// Purpose: bench for control pins
// Assumes: shortened counts
// Notes: xorshift stimulus
`timescale 1ns/10ps
module mcp_control_pins_test;
reg sys_clk = 1'b0;
reg doReset = 1'b1;
reg press = 1'b0;
reg [7:0] pressLen = 8'h00;
reg apAssociated = 1'b0;
reg upgradeActivity = 1'b0;
reg provDone = 1'b0;
reg [5:0] pulseEnable = 6'h00;
reg [191:0] pulsePeriod = 192'h0;
reg [191:0] pulseHigh = 192'h0;
reg [31:0] seed = 32'h2AF2;
integer errors = 0;
integer check_count = 0;
integer i, n, p, h;
wire rst_n, reload_button_n, boot_done_n, wifi_link_n;
wire provisionMode, upgradeMode, factoryRestore;
wire [5:0] pulse_out;
always #25 sys_clk = ~sys_clk;
mcp_control_pins #(.SHORT_CYCLES(20), .LONG_CYCLES(40), .BOOT_CYCLES(10),
    .RESTORE_CYCLES(5)) dut (.sys_clk, .rst_n, .reload_button_n, .apAssociated,
    .upgradeActivity, .provDone, .pulseEnable, .pulsePeriod, .pulseHigh,
    .boot_done_n, .wifi_link_n, .provisionMode, .upgradeMode, .factoryRestore, .pulse_out);
mcp_host_model host (.sys_clk, .doReset, .press, .pressLen, .boot_done_n, .rst_n,
    .reload_button_n, .serialOk());
function [31:0] xs(input [31:0] v);
    reg [31:0] t;
begin
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
end
endfunction
task check(input [31:0] seen, input [31:0] exp, input [39:0] what);
begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
        errors = errors + 1;
        $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
    end
end
endtask
task tick(input integer k);
    repeat (k) @(posedge sys_clk);
endtask
task hit(input [7:0] len, input integer wt);
begin
    seed = xs(seed);
    press <= 1'b1;
    pressLen <= len;
    tick(1);
    press <= 1'b0;
    tick(len + wt);
end
endtask
task conclude;
begin
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
end
endtask
initial
begin
    tick(2);
    doReset <= 1'b0;
    tick(22);
    check(boot_done_n, 1, "boot");
    tick(14);
    check(boot_done_n, 0, "ready");
    $display("boot test done");
    for (i = 0; i < 6; i = i + 1)
    begin
        seed = xs(seed);
        apAssociated <= seed[0];
        p = 4 + seed[4:1];
        h = 1 + seed[8:5] % p;
        pulsePeriod[i*32 +: 32] <= p;
        pulseHigh[i*32 +: 32] <= h;
        pulseEnable[i] <= 1'b1;
        tick(p + 6);
        check(wifi_link_n, !seed[0], "link");
        n = 0;
        repeat (4 * p)
        begin
            @(posedge sys_clk);
            n = n + pulse_out[i];
        end
        check(n, 4 * h, "pulse");
    end
    $display("pulse test done");
    hit(24 + seed % 12, 8);
    check({provisionMode, factoryRestore}, 0, "mid");
    hit(20, 8);
    check({provisionMode, factoryRestore}, 0, "mid20");
    hit(40, 8);
    check({provisionMode, factoryRestore}, 0, "mid40");
    hit(5 + seed % 10, 8);
    check(provisionMode, 1, "prov");
    provDone <= 1'b1;
    tick(5);
    check(wifi_link_n, 0, "plnk1");
    provDone <= 1'b0;
    tick(5);
    check(wifi_link_n, 1, "plnk0");
    hit(46 + seed % 10, 6);
    check(factoryRestore, 1, "rest");
    tick(20);
    check({boot_done_n, provisionMode}, 0, "boot2");
    $display("button test done");
    doReset <= 1'b1;
    tick(2);
    doReset <= 1'b0;
    // button goes low during reset and stays low well past its release
    hit(60, 20);
    check({upgradeMode, boot_done_n}, 3, "upg");
    upgradeActivity <= 1'b1;
    tick(5);
    check(wifi_link_n, 0, "ulnk1");
    upgradeActivity <= 1'b0;
    tick(5);
    check(wifi_link_n, 1, "ulnk0");
    $display("end of tests");
    conclude;
end
initial
begin
    #200000;
    errors = errors + 1;
    conclude;
end
endmodule // mcp_control_pins_test
